// ---- core/shta_pkg.sv ----
// Purpose: Shared constants and types for the packed subtract and test datapath.
// Assumes: One AXI4-Lite register slave on a single 25 MHz clock.
// Notes: All command, flag and bus field positions live here.
//
// Notes on behaviour
// - Add-sub-exchange top: halved first-top plus second-bottom.
// - Add-sub-exchange bottom: halved first-bottom minus second-top.
// - Sub-add-exchange top: halved first-top minus second-bottom.
// - Sub-add-exchange bottom: halved first-bottom plus second-top.
// - Exchange halving ops leave all flags alone.
// - Halving halfword subtract, halved per lane.
// - Halving byte subtract, four halved lanes.
// - Halving subtracts leave all flags alone.
// - Halfword subtract writes low sixteen bits.
// - Halfword subtract sets lane flag pairs.
// - Byte subtract writes low eight bits.
// - Byte subtract sets each lane flag.
// - Missing destination means first operand register.
// - Failed condition leaves registers and flags untouched.
// - AND test updates flags, writes nothing.
// - XOR test updates flags, discards value.
// - Tests set N from bit 31, Z.
// - Tests change carry only from shifter.
// - Tests leave overflow flag unchanged.
package shta_pkg;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_OPA = 8'h00;
  localparam logic [7:0] REG_OPB = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_RES = 8'h0C;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_WB = 8'h14;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_COND_BIT = 4;
  localparam int CMD_DGIVEN_BIT = 5;
  localparam int CMD_DEST_LSB = 8;
  localparam int CMD_SRC_LSB = 12;
  localparam int CMD_CVALID_BIT = 16;
  localparam int CMD_CIN_BIT = 17;
  localparam logic [2:0] OP_HADD_SUB_X = 3'h0;
  localparam logic [2:0] OP_HSUB_ADD_X = 3'h1;
  localparam logic [2:0] OP_HSUB_H = 3'h2;
  localparam logic [2:0] OP_HSUB_B = 3'h3;
  localparam logic [2:0] OP_SUB_H = 3'h4;
  localparam logic [2:0] OP_SUB_B = 3'h5;
  localparam logic [2:0] OP_AND_TEST = 3'h6;
  localparam logic [2:0] OP_XOR_TEST = 3'h7;
  localparam logic [3:0] IDX_SP = 4'hD;
  localparam logic [3:0] IDX_PC = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // Flag byte as software sees it: N Z C V in bits 7..4, lane flags in 3..0.
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
    logic [3:0] ge;
  } shta_flags_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] cmd;
    logic [31:0] result;
    shta_flags_t flags;
    logic rf_we;
    logic [3:0] rf_waddr;
    logic [31:0] rf_wdata;
    logic wb_wrote;
  } shta_state_t;
endpackage

// ---- core/shta_alu.sv ----
// Purpose: Packed signed subtract, halving exchange and bit test datapath slice.
// Assumes: Operands and command arrive over AXI4-Lite; results leave on a write port.
// Notes: A command executes in the cycle after its address and data are both accepted on the bus.
`timescale 1ns/1ps
module shta_alu #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic rf_we,
  output logic [3:0] rf_waddr,
  output logic [31:0] rf_wdata,
  output shta_pkg::shta_flags_t flags
);

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  shta_pkg::shta_state_t st_q;
  shta_pkg::shta_state_t st_d;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic reg_mapped(input logic [7:0] word);
    return word == shta_pkg::REG_OPA || word == shta_pkg::REG_OPB ||
           word == shta_pkg::REG_CMD || word == shta_pkg::REG_RES ||
           word == shta_pkg::REG_FLAGS || word == shta_pkg::REG_WB;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Lane arithmetic. Every lane is sign extended by one bit and computed on its own.

  logic [3:0][8:0] bdiff;
  logic [1:0][16:0] hdiff;
  logic [1:0][16:0] xsum;
  logic [1:0][16:0] xdiff;

  for (genvar i = 0; i < 4; i++) begin : g_byte
    assign bdiff[i] = {st_q.opa[8*i+7], st_q.opa[8*i +: 8]}
                    - {st_q.opb[8*i+7], st_q.opb[8*i +: 8]};
  end

  for (genvar i = 0; i < 2; i++) begin : g_half
    localparam int J = 1 - i;
    assign hdiff[i] = {st_q.opa[16*i+15], st_q.opa[16*i +: 16]}
                    - {st_q.opb[16*i+15], st_q.opb[16*i +: 16]};
    assign xsum[i] = {st_q.opa[16*i+15], st_q.opa[16*i +: 16]}
                   + {st_q.opb[16*J+15], st_q.opb[16*J +: 16]};
    assign xdiff[i] = {st_q.opa[16*i+15], st_q.opa[16*i +: 16]}
                    - {st_q.opb[16*J+15], st_q.opb[16*J +: 16]};
  end

  ////////////////////////////////////////////////////////////////////////////////

  logic wr_go;
  logic [7:0] wr_word;
  logic [7:0] rd_word;
  logic [31:0] cmd_new;
  logic [31:0] fl_new;
  logic [2:0] exec_op;
  logic [3:0] src_idx;
  logic [3:0] dest_idx;
  logic is_test;
  logic cmd_hit;
  logic cmd_bad;
  logic exec;
  logic cmd_skip;
  logic ge_upd;
  logic [3:0] pk_ge;
  logic [31:0] pk_res;
  logic [31:0] tst_res;

  always_comb begin
    st_d = st_q;
    st_d.rf_we = 1'b0;
    wr_go = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    wr_word = {st_q.awaddr[7:2], 2'b00};
    rd_word = {araddr[7:2], 2'b00};
    cmd_new = merge(st_q.cmd, st_q.wdata, st_q.wstrb);
    fl_new = merge({24'h000000, st_q.flags}, st_q.wdata, st_q.wstrb);
    exec_op = cmd_new[shta_pkg::CMD_OP_LSB +: 3];
    src_idx = cmd_new[shta_pkg::CMD_SRC_LSB +: 4];
    is_test = exec_op == shta_pkg::OP_AND_TEST || exec_op == shta_pkg::OP_XOR_TEST;
    dest_idx = cmd_new[shta_pkg::CMD_DGIVEN_BIT] ? cmd_new[shta_pkg::CMD_DEST_LSB +: 4]
                                                  : src_idx;
    cmd_bad = src_idx == shta_pkg::IDX_SP || src_idx == shta_pkg::IDX_PC ||
              (!is_test && (dest_idx == shta_pkg::IDX_SP || dest_idx == shta_pkg::IDX_PC));
    cmd_hit = wr_go && wr_word == shta_pkg::REG_CMD;
    exec = cmd_hit && !cmd_bad && cmd_new[shta_pkg::CMD_COND_BIT];
    cmd_skip = cmd_hit && !cmd_bad && !cmd_new[shta_pkg::CMD_COND_BIT];
    ge_upd = 1'b0;
    pk_ge = st_q.flags.ge;
    pk_res = 32'h00000000;
    tst_res = 32'h00000000;
    case (exec_op)
      shta_pkg::OP_HADD_SUB_X: begin
        pk_res = {xsum[1][16:1], xdiff[0][16:1]};
      end
      shta_pkg::OP_HSUB_ADD_X: begin
        pk_res = {xdiff[1][16:1], xsum[0][16:1]};
      end
      shta_pkg::OP_HSUB_H: begin
        pk_res = {hdiff[1][16:1], hdiff[0][16:1]};
      end
      shta_pkg::OP_HSUB_B: begin
        pk_res = {bdiff[3][8:1], bdiff[2][8:1], bdiff[1][8:1], bdiff[0][8:1]};
      end
      shta_pkg::OP_SUB_H: begin
        pk_res = {hdiff[1][15:0], hdiff[0][15:0]};
        pk_ge = {{2{~hdiff[1][16]}}, {2{~hdiff[0][16]}}};
        ge_upd = 1'b1;
      end
      shta_pkg::OP_SUB_B: begin
        pk_res = {bdiff[3][7:0], bdiff[2][7:0], bdiff[1][7:0], bdiff[0][7:0]};
        pk_ge = ~{bdiff[3][8], bdiff[2][8], bdiff[1][8], bdiff[0][8]};
        ge_upd = 1'b1;
      end
      shta_pkg::OP_AND_TEST: begin
        tst_res = st_q.opa & st_q.opb;
      end
      shta_pkg::OP_XOR_TEST: begin
        tst_res = st_q.opa ^ st_q.opb;
      end
      default: begin
        pk_res = 32'h00000000;
      end
    endcase

    if (awvalid && st_q.awready) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = awaddr[7:0];
    end
    if (wvalid && st_q.wready) begin
      st_d.w_got = 1'b1;
      st_d.wdata = wdata;
      st_d.wstrb = wstrb;
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = reg_mapped(wr_word) ? shta_pkg::RESP_OKAY : shta_pkg::RESP_SLVERR;
      case (wr_word)
        shta_pkg::REG_OPA: begin
          st_d.opa = merge(st_q.opa, st_q.wdata, st_q.wstrb);
        end
        shta_pkg::REG_OPB: begin
          st_d.opb = merge(st_q.opb, st_q.wdata, st_q.wstrb);
        end
        shta_pkg::REG_FLAGS: begin
          st_d.flags = fl_new[7:0];
        end
        shta_pkg::REG_CMD: begin
          if (cmd_bad) begin
            st_d.bresp = shta_pkg::RESP_SLVERR;
          end else begin
            st_d.cmd = cmd_new;
          end
        end
        default: begin
          st_d.bresp = st_d.bresp;
        end
      endcase
    end

    if (exec) begin
      if (is_test) begin
        // N and Z from test value
        st_d.flags.n = tst_res[31];
        st_d.flags.z = tst_res == 32'h00000000;
        if (cmd_new[shta_pkg::CMD_CVALID_BIT]) begin
          st_d.flags.c = cmd_new[shta_pkg::CMD_CIN_BIT];
        end
        st_d.wb_wrote = 1'b0;
      end else begin
        st_d.rf_we = 1'b1;
        st_d.rf_waddr = dest_idx;
        st_d.rf_wdata = pk_res;
        st_d.result = pk_res;
        st_d.wb_wrote = 1'b1;
        // only plain subtracts touch lane flags
        if (ge_upd) begin
          st_d.flags.ge = pk_ge;
        end
      end
    end

    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    if (arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = reg_mapped(rd_word) ? shta_pkg::RESP_OKAY : shta_pkg::RESP_SLVERR;
      case (rd_word)
        shta_pkg::REG_OPA: st_d.rdata = st_q.opa;
        shta_pkg::REG_OPB: st_d.rdata = st_q.opb;
        shta_pkg::REG_CMD: st_d.rdata = st_q.cmd;
        shta_pkg::REG_RES: st_d.rdata = st_q.result;
        shta_pkg::REG_FLAGS: st_d.rdata = {24'h000000, st_q.flags};
        shta_pkg::REG_WB: st_d.rdata = {27'h0000000, st_q.rf_waddr, st_q.wb_wrote};
        default: st_d.rdata = 32'h00000000;
      endcase
    end

    // Ready is registered so each bus output comes straight from a flop.
    st_d.awready = !st_d.aw_got && !st_d.bvalid;
    st_d.wready = !st_d.w_got && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.flags <= shta_pkg::FLAGS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rresp = st_q.rresp;
  assign rdata = st_q.rdata;
  assign rf_we = st_q.rf_we;
  assign rf_waddr = st_q.rf_waddr;
  assign rf_wdata = st_q.rf_wdata;
  assign flags = st_q.flags;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks of the datapath against an independent integer reference.

  function automatic logic [15:0] half_ref(input logic [15:0] a, input logic [15:0] b,
                                           input logic sub);
    int s;
    s = sub ? (int'($signed(a)) - int'($signed(b))) : (int'($signed(a)) + int'($signed(b)));
    s = s >>> 1;
    return s[15:0];
  endfunction

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_packed_exec;
    exec && !is_test;
  endsequence

  sequence s_writeback(logic [3:0] idx);
    st_q.rf_we && st_q.rf_waddr == idx;
  endsequence

  exch_flags_a: assert property (
    exec && (exec_op == shta_pkg::OP_HADD_SUB_X || exec_op == shta_pkg::OP_HSUB_ADD_X)
    |=> $stable(st_q.flags) && st_q.rf_we)
    else $error("Exchange operation changed flags.");

  hsub_flags_a: assert property (
    exec && (exec_op == shta_pkg::OP_HSUB_H || exec_op == shta_pkg::OP_HSUB_B)
    |=> $stable(st_q.flags))
    else $error("Halving subtract changed flags.");

  asx_top_a: assert property (
    exec && exec_op == shta_pkg::OP_HADD_SUB_X
    |=> st_q.rf_wdata[31:16] == half_ref($past(st_q.opa[31:16]), $past(st_q.opb[15:0]), 1'b0))
    else $error("Add-sub-exchange top half wrong.");

  asx_bottom_a: assert property (
    exec && exec_op == shta_pkg::OP_HADD_SUB_X
    |=> st_q.rf_wdata[15:0] == half_ref($past(st_q.opa[15:0]), $past(st_q.opb[31:16]), 1'b1))
    else $error("Add-sub-exchange bottom half wrong.");

  sax_bottom_a: assert property (
    exec && exec_op == shta_pkg::OP_HSUB_ADD_X
    |=> st_q.rf_wdata[15:0] == half_ref($past(st_q.opa[15:0]), $past(st_q.opb[31:16]), 1'b0))
    else $error("Sub-add-exchange bottom half wrong.");

  sub16_ge_a: assert property (
    exec && exec_op == shta_pkg::OP_SUB_H
    |=> st_q.flags.ge[3:2] == {2{$signed($past(st_q.opa[31:16]))
                                 >= $signed($past(st_q.opb[31:16]))}}
        && st_q.flags.ge[1:0] == {2{$signed($past(st_q.opa[15:0]))
                                    >= $signed($past(st_q.opb[15:0]))}})
    else $error("Halfword lane flags wrong.");

  sub8_low_a: assert property (
    exec && exec_op == shta_pkg::OP_SUB_B
    |=> st_q.rf_wdata[15:8] == 8'($past(st_q.opa[15:8]) - $past(st_q.opb[15:8])))
    else $error("Byte difference wrong.");

  sub8_ge_a: assert property (
    exec && exec_op == shta_pkg::OP_SUB_B
    |=> st_q.flags.ge[0] == ($signed($past(st_q.opa[7:0])) >= $signed($past(st_q.opb[7:0]))))
    else $error("Byte lane flag wrong.");

  test_flags_a: assert property (
    exec && exec_op == shta_pkg::OP_XOR_TEST
    |=> !st_q.rf_we && st_q.flags.n == ($past(st_q.opa[31]) ^ $past(st_q.opb[31]))
        && $stable(st_q.flags.v) && st_q.flags.z == ($past(st_q.opa) == $past(st_q.opb)))
    else $error("Test operation flags wrong.");

  test_carry_a: assert property (
    exec && is_test && !cmd_new[shta_pkg::CMD_CVALID_BIT] |=> $stable(st_q.flags.c))
    else $error("Test changed carry without shifter carry.");

  cond_skip_a: assert property (
    cmd_skip |=> !st_q.rf_we && $stable(st_q.flags) && $stable(st_q.result))
    else $error("Failed condition still took effect.");

  dest_sel_a: assert property (
    s_packed_exec |=> s_writeback($past(dest_idx)) ##1 !st_q.rf_we)
    else $error("Writeback not a single pulse to the chosen register.");

endmodule

// ---- tb/shta_rf_model.sv ----
// Purpose: Register file behind the write-back port of the datapath.
// Assumes: One register write for each cycle that rf_we is high.
// Notes: Counters let the bench see pulse width and stray writes.
`timescale 1ns/1ps
module shta_rf_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rf_we,
  input wire logic [3:0] rf_waddr,
  input wire logic [31:0] rf_wdata,
  output logic [7:0] wr_count,
  output logic [3:0] last_idx,
  output logic [31:0] last_val,
  output logic [7:0] bad_count
);
  logic [31:0] regs_q [16];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_count <= 8'h00;
      last_idx <= 4'h0;
      last_val <= 32'h0000_0000;
      bad_count <= 8'h00;
    end else if (rf_we) begin
      regs_q[rf_waddr] <= rf_wdata;
      wr_count <= wr_count + 8'h01;
      last_idx <= rf_waddr;
      last_val <= rf_wdata;
      if (rf_waddr == shta_pkg::IDX_SP || rf_waddr == shta_pkg::IDX_PC) begin
        bad_count <= bad_count + 8'h01;
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the packed subtract and test slice.
// Assumes: Register map and command layout as the package gives them.
// Notes: Expected values come from a local lane-by-lane reference.
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rf_we;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rf_wdata, last_val;
  logic [3:0] rf_waddr, last_idx;
  logic [7:0] wr_count, bad_count;
  shta_pkg::shta_flags_t flags;
  logic [7:0] exp_flags = shta_pkg::FLAGS_RST;
  logic [31:0] exp_res = 32'h0000_0000;
  logic [31:0] exp_wb = 32'h0000_0000;
  logic [31:0] exp_val = 32'h0000_0000;
  logic [7:0] exp_wr = 8'h00;
  logic [3:0] exp_idx = 4'h0;
  int fail_count = 0;
  int checked = 0;

  always #20 aclk = ~aclk;

  shta_alu dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .flags(flags));

  shta_rf_model rf (.aclk(aclk), .aresetn(aresetn), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata), .wr_count(wr_count), .last_idx(last_idx), .last_val(last_val),
    .bad_count(bad_count));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang(input int n);
    if (n >= 200) begin
      fail_count++;
      $display("mismatch at %0t: bus wait ran out", $time);
      results();
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    hang(n);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    hang(n);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Returns the new flag byte above the 32-bit lane result.
  function automatic logic [39:0] ref_op(input logic [2:0] op, input logic [31:0] a,
      input logic [31:0] b, input logic [7:0] f, input logic cv, input logic ci);
    logic [31:0] r;
    logic [7:0] nf;
    logic [16:0] h;
    logic [8:0] e;
    logic sub;
    r = a ^ b;
    nf = f;
    sub = (op == shta_pkg::OP_HSUB_ADD_X);
    case (op)
      shta_pkg::OP_HADD_SUB_X, shta_pkg::OP_HSUB_ADD_X: begin
        h = sub ? {a[31], a[31:16]} - {b[15], b[15:0]} : {a[31], a[31:16]} + {b[15], b[15:0]};
        r[31:16] = h[16:1];
        h = sub ? {a[15], a[15:0]} + {b[31], b[31:16]} : {a[15], a[15:0]} - {b[31], b[31:16]};
        r[15:0] = h[16:1];
      end
      shta_pkg::OP_HSUB_H, shta_pkg::OP_SUB_H: begin
        for (int i = 0; i < 2; i++) begin
          h = {a[16*i+15], a[16*i+:16]} - {b[16*i+15], b[16*i+:16]};
          r[16*i+:16] = (op == shta_pkg::OP_SUB_H) ? h[15:0] : h[16:1];
          if (op == shta_pkg::OP_SUB_H) nf[2*i+:2] = {2{~h[16]}};
        end
      end
      shta_pkg::OP_HSUB_B, shta_pkg::OP_SUB_B: begin
        for (int i = 0; i < 4; i++) begin
          e = {a[8*i+7], a[8*i+:8]} - {b[8*i+7], b[8*i+:8]};
          r[8*i+:8] = (op == shta_pkg::OP_SUB_B) ? e[7:0] : e[8:1];
          if (op == shta_pkg::OP_SUB_B) nf[i] = ~e[8];
        end
      end
      default: begin
        r = (op == shta_pkg::OP_AND_TEST) ? (a & b) : (a ^ b);
        nf[7] = r[31];
        nf[6] = (r == 32'h0);
        if (cv) nf[5] = ci;
      end
    endcase
    return {nf, r};
  endfunction

  task automatic check_state();
    bus_rd(shta_pkg::REG_FLAGS, {24'h0, exp_flags}, shta_pkg::RESP_OKAY);
    bus_rd(shta_pkg::REG_RES, exp_res, shta_pkg::RESP_OKAY);
    bus_rd(shta_pkg::REG_WB, exp_wb, shta_pkg::RESP_OKAY);
    chk({24'h0, flags}, {24'h0, exp_flags});
    chk({24'h0, wr_count}, {24'h0, exp_wr});
    chk({28'h0, last_idx}, {28'h0, exp_idx});
    chk(last_val, exp_val);
    if (exp_wr != 8'h00) chk(rf.regs_q[exp_idx], exp_val);
  endtask

  // The control nibble holds condition, destination given, carry valid and carry in.
  task automatic run(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
      input logic [3:0] ctl, input logic [3:0] dst, input logic [3:0] src);
    logic [39:0] rv;
    logic [3:0] di;
    rv = ref_op(op, a, b, exp_flags, ctl[1], ctl[0]);
    di = ctl[2] ? dst : src;
    bus_wr(shta_pkg::REG_OPA, a, shta_pkg::RESP_OKAY);
    bus_wr(shta_pkg::REG_OPB, b, shta_pkg::RESP_OKAY);
    bus_wr(shta_pkg::REG_CMD, {14'h0, ctl[0], ctl[1], src, dst, 2'h0, ctl[2], ctl[3], 1'b0, op},
      shta_pkg::RESP_OKAY);
    if (ctl[3]) begin
      exp_flags = rv[39:32];
      // A test keeps the last written index and clears the wrote bit.
      exp_wb = {27'h0, exp_idx, 1'b0};
      if (op < shta_pkg::OP_AND_TEST) begin
        exp_res = rv[31:0];
        exp_val = rv[31:0];
        exp_wr++;
        exp_idx = di;
        exp_wb = {27'h0, di, 1'b1};
      end
    end
    check_state();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_state();
    bus_wr(shta_pkg::REG_FLAGS, 32'h0000_005A, shta_pkg::RESP_OKAY);
    exp_flags = 8'h5A;
    run(shta_pkg::OP_HADD_SUB_X, 32'h7FFF_8000, 32'h8001_7FFF, 4'hC, 4'h2, 4'h3);
    run(shta_pkg::OP_HSUB_ADD_X, 32'h7FFF_8000, 32'h8001_7FFF, 4'h8, 4'h2, 4'h3);
    run(shta_pkg::OP_HSUB_H, 32'h8000_7FFF, 32'h7FFF_8000, 4'hC, 4'h5, 4'h1);
    run(shta_pkg::OP_HSUB_B, 32'h807F_0180, 32'h7F80_FF01, 4'hC, 4'h6, 4'h1);
    run(shta_pkg::OP_SUB_H, 32'h0000_8000, 32'h0001_0001, 4'hC, 4'h7, 4'h1);
    run(shta_pkg::OP_SUB_H, 32'h7FFF_0005, 32'h8000_0005, 4'hC, 4'h8, 4'h1);
    run(shta_pkg::OP_SUB_B, 32'h0180_7F00, 32'h0201_8001, 4'hC, 4'h9, 4'h1);
    run(shta_pkg::OP_SUB_B, 32'h0102_0304, 32'h0201_8000, 4'h4, 4'hA, 4'h1);
    run(shta_pkg::OP_AND_TEST, 32'hF0F0_0000, 32'h0F0F_FFFF, 4'hB, 4'h0, 4'h2);
    run(shta_pkg::OP_XOR_TEST, 32'h8000_0001, 32'h0000_0001, 4'h9, 4'h0, 4'h2);
    run(shta_pkg::OP_XOR_TEST, 32'h1234_5678, 32'h1234_5678, 4'hA, 4'h0, 4'h2);
    bus_wr(shta_pkg::REG_CMD, 32'h0000_D315, shta_pkg::RESP_SLVERR);
    bus_wr(shta_pkg::REG_CMD, 32'h0000_1F35, shta_pkg::RESP_SLVERR);
    bus_wr(shta_pkg::REG_RES, 32'h1234_5678, shta_pkg::RESP_OKAY);
    bus_wr(8'h1C, 32'hFFFF_FFFF, shta_pkg::RESP_SLVERR);
    bus_rd(8'h18, 32'h0000_0000, shta_pkg::RESP_SLVERR);
    // Only byte lane 1 is enabled, so the flag byte must stay as it was.
    wstrb <= 4'h2;
    bus_wr(shta_pkg::REG_FLAGS, 32'h0000_00FF, shta_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    check_state();
    chk({24'h0, bad_count}, 32'h0000_0000);
    results();
  end
endmodule
